// File: rtl/mss_sequencer.sv
// multi-segment speed reference sequencer with AHB-Lite register slave
`timescale 1ns/1ps

module mss_sequencer #(
  parameter int TICK_SEC = mss_pkg::TICK_SEC_CYC,
  parameter int TICK_MIN = mss_pkg::TICK_MIN_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        segment_select_bit0,
  input  wire logic        segment_select_bit1,
  input  wire logic        segment_select_bit2,
  input  wire logic        segment_select_bit3,
  input  wire logic        dirSelect,
  output logic      [15:0] sourceBSpeed,
  output logic             sourceBActive,
  output logic      [15:0] rampTime,
  output logic      [15:0] accelTime,
  output logic      [15:0] decelTime,
  output logic      [3:0]  activeSegment,
  output logic             modeSwitchAllowed,
  output logic             seqRunning
);
  // ****************************************************************
  // register slave
  // ****************************************************************
  logic [15:0] runMode_reg, endSeg_reg, timeUnit_reg, srcBSel_reg, combine_reg;
  logic [15:0] genAccel_reg, genDecel_reg, ctrlMode_reg;
  logic [15:0] ramp_reg [mss_pkg::NUM_RAMP];
  logic        wrPend_reg;
  logic [8:0]  addr_reg;
  logic [31:0] hrdata_reg;
  logic        rdSel_reg;
  logic        addrPhase;
  logic [15:0] memRdB;
  logic [15:0] memRdA;
  logic [5:0]  memRaddrA;
  logic [5:0]  memWaddr;
  logic        memWe;
  logic [31:0] statusWord;

  // segment memory runs 48 words past its base, beyond an 8-bit address
  function automatic logic isMem(input logic [8:0] a);
    return a >= {1'b0, mss_pkg::REG_SEG_BASE} &&
           a < 9'({1'b0, mss_pkg::REG_SEG_BASE} + 9'd192);
  endfunction

  function automatic logic [5:0] memIdx(input logic [8:0] a);
    logic [8:0] d;
    d = 9'(a - {1'b0, mss_pkg::REG_SEG_BASE});
    return d[7:2];
  endfunction

  assign addrPhase = hsel && hready && (htrans == mss_pkg::HTRANS_NONSEQ ||
                     htrans == mss_pkg::HTRANS_SEQ);
  assign memWe     = wrPend_reg && isMem(addr_reg);
  assign memWaddr  = memIdx(addr_reg);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wrPend_reg <= 1'b0;
      addr_reg   <= 9'h000;
    end
    else
    begin
      wrPend_reg <= addrPhase && hwrite;
      if (addrPhase)
      begin
        addr_reg <= haddr[8:0];
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      runMode_reg  <= mss_pkg::RST_RUN_MODE;
      endSeg_reg   <= mss_pkg::RST_END_SEG;
      timeUnit_reg <= mss_pkg::RST_TIME_UNIT;
      srcBSel_reg  <= 16'h0000;
      combine_reg  <= 16'h0000;
      genAccel_reg <= 16'h0000;
      genDecel_reg <= 16'h0000;
      ctrlMode_reg <= 16'h0000;
      for (int i = 0; i < mss_pkg::NUM_RAMP; i++)
      begin
        ramp_reg[i] <= 16'h0000;
      end
    end
    else if (wrPend_reg && !isMem(addr_reg))
    begin
      unique case (addr_reg[7:0])
        mss_pkg::REG_RUN_MODE:  runMode_reg  <= hwdata[15:0];
        mss_pkg::REG_END_SEG:   endSeg_reg   <= hwdata[15:0];
        mss_pkg::REG_TIME_UNIT: timeUnit_reg <= hwdata[15:0];
        mss_pkg::REG_SRC_B_SEL: srcBSel_reg  <= hwdata[15:0];
        mss_pkg::REG_COMBINE:   combine_reg  <= hwdata[15:0];
        mss_pkg::REG_GEN_ACCEL: genAccel_reg <= hwdata[15:0];
        mss_pkg::REG_GEN_DECEL: genDecel_reg <= hwdata[15:0];
        mss_pkg::REG_CTRL_MODE: ctrlMode_reg <= hwdata[15:0];
        8'h40, 8'h44, 8'h48, 8'h4c: ramp_reg[addr_reg[3:2]] <= hwdata[15:0];
        default: ;
      endcase
    end
  end

  // read data of the register file, taken up by the wait-state flop below
  always_comb
  begin
    unique case (addr_reg[7:0])
      mss_pkg::REG_RUN_MODE:  hrdata_reg = {16'h0000, runMode_reg};
      mss_pkg::REG_END_SEG:   hrdata_reg = {16'h0000, endSeg_reg};
      mss_pkg::REG_TIME_UNIT: hrdata_reg = {16'h0000, timeUnit_reg};
      mss_pkg::REG_SRC_B_SEL: hrdata_reg = {16'h0000, srcBSel_reg};
      mss_pkg::REG_COMBINE:   hrdata_reg = {16'h0000, combine_reg};
      mss_pkg::REG_GEN_ACCEL: hrdata_reg = {16'h0000, genAccel_reg};
      mss_pkg::REG_GEN_DECEL: hrdata_reg = {16'h0000, genDecel_reg};
      mss_pkg::REG_CTRL_MODE: hrdata_reg = {16'h0000, ctrlMode_reg};
      mss_pkg::REG_STATUS:    hrdata_reg = statusWord;
      8'h40, 8'h44, 8'h48, 8'h4c: hrdata_reg = {16'h0000, ramp_reg[addr_reg[3:2]]};
      default:                hrdata_reg = 32'h0000_0000;
    endcase
  end

  // one wait state per read, so hrdata leaves a flop on the same edge that raises hreadyout
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdSel_reg <= 1'b0;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
    end
    else
    begin
      rdSel_reg <= 1'b0;
      if (addrPhase && !hwrite)
      begin
        hreadyout <= 1'b0;
        rdSel_reg <= 1'b1;
      end
      else if (rdSel_reg)
      begin
        hreadyout <= 1'b1;
        hrdata    <= isMem(addr_reg) ? {16'h0000, memRdA} : hrdata_reg;
      end
    end
  end

  assign hresp     = 1'b0;
  assign memRaddrA = (addrPhase && !hwrite) ? memIdx(haddr[8:0]) : memIdx(addr_reg);

  // ****************************************************************
  // segment sequencer
  // ****************************************************************
  mss_pkg::mss_state_t state_reg, state_next;
  logic [3:0]  seg_reg, seg_next;
  logic [15:0] tenths_reg, tenths_next;
  logic [31:0] tick_reg, tick_next;
  logic [5:0]  memRaddrB;
  logic [1:0]  field_reg, field_next;
  logic [15:0] spd_reg, spd_next, runT_reg, runT_next, rsel_reg, rsel_next;
  logic [3:0]  selIn;
  logic        msActive;
  logic [3:0]  lastSeg;
  logic        tickDone;

  assign selIn    = {segment_select_bit3, segment_select_bit2,
                     segment_select_bit1, segment_select_bit0};
  assign msActive = srcBSel_reg == mss_pkg::SRC_B_MULTISEG;
  assign lastSeg  = (endSeg_reg >= 16'd1 && endSeg_reg <= 16'd16) ?
                    4'(endSeg_reg - 16'd1) : 4'hf;
  assign tickDone = tick_reg >= ((timeUnit_reg == 16'h0000) ? 32'(TICK_SEC - 1)
                                 : 32'(TICK_MIN - 1));
  // three words per segment: speed, run time, ramp select
  assign memRaddrB = 6'(seg_reg * mss_pkg::SEG_STRIDE) + {4'h0, field_reg};

  mss_seg_mem u_mem (
    .clk    (clk),
    .we     (memWe),
    .waddr  (memWaddr),
    .wdata  (hwdata[15:0]),
    .raddrA (memRaddrA),
    .rdataA (memRdA),
    .raddrB (memRaddrB),
    .rdataB (memRdB)
  );

  always_comb
  begin
    state_next  = state_reg;
    seg_next    = seg_reg;
    tenths_next = tenths_reg;
    tick_next   = tick_reg;
    field_next  = (field_reg == 2'd2) ? 2'd0 : 2'(field_reg + 2'd1);
    spd_next    = spd_reg;
    runT_next   = runT_reg;
    rsel_next   = rsel_reg;
    // parameter fetch cycles through the three words of the segment
    unique case (field_reg)
      2'd1: spd_next  = memRdB;
      2'd2: runT_next = memRdB;
      2'd0: rsel_next = memRdB;
      default: ;
    endcase
    if (!msActive)
    begin
      state_next  = mss_pkg::MSS_IDLE;
      seg_next    = 4'h0;
      tenths_next = 16'h0000;
      tick_next   = 32'h0;
    end
    else if (runMode_reg == mss_pkg::MODE_DIRECT)
    begin
      state_next = mss_pkg::MSS_RUN;
      seg_next   = selIn;
    end
    else
    begin
      unique case (state_reg)
        mss_pkg::MSS_IDLE:
        begin
          state_next  = mss_pkg::MSS_RUN;
          seg_next    = 4'h0;
          tenths_next = 16'h0000;
          tick_next   = 32'h0;
        end
        mss_pkg::MSS_RUN:
        begin
          tick_next = tickDone ? 32'h0 : tick_reg + 32'h1;
          if (tickDone)
          begin
            tenths_next = tenths_reg + 16'h1;
          end
          // time counts from entry; step once it elapses
          if (tenths_reg >= runT_reg && field_reg == 2'd0)
          begin
            tenths_next = 16'h0000;
            tick_next   = 32'h0;
            if (seg_reg >= lastSeg)
            begin
              if (runMode_reg == mss_pkg::MODE_CYCLE)
              begin
                seg_next = 4'h0;
              end
              else
              begin
                state_next = mss_pkg::MSS_DONE;
              end
            end
            else
            begin
              seg_next = seg_reg + 4'h1;
            end
          end
        end
        mss_pkg::MSS_DONE: ;
        default: state_next = mss_pkg::MSS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg  <= mss_pkg::MSS_IDLE;
      seg_reg    <= 4'h0;
      tenths_reg <= 16'h0000;
      tick_reg   <= 32'h0;
      field_reg  <= 2'd0;
      spd_reg    <= 16'h0000;
      runT_reg   <= 16'h0000;
      rsel_reg   <= 16'h0000;
    end
    else
    begin
      state_reg  <= state_next;
      seg_reg    <= seg_next;
      tenths_reg <= tenths_next;
      tick_reg   <= tick_next;
      field_reg  <= field_next;
      spd_reg    <= spd_next;
      runT_reg   <= runT_next;
      rsel_reg   <= rsel_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  logic [15:0] segRamp;
  logic        segRampMode;

  always_comb
  begin
    segRamp = 16'h0000;
    if (rsel_reg >= 16'd1 && rsel_reg <= 16'd4)
    begin
      segRamp = ramp_reg[2'(rsel_reg - 16'd1)];
    end
  end

  assign segRampMode = msActive && (combine_reg == mss_pkg::COMB_B_ONLY ||
                       combine_reg == mss_pkg::COMB_A_PLUS_B ||
                       combine_reg == mss_pkg::COMB_A_B_SWITCH);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sourceBSpeed      <= 16'h0000;
      sourceBActive     <= 1'b0;
      rampTime          <= 16'h0000;
      accelTime         <= 16'h0000;
      decelTime         <= 16'h0000;
      activeSegment     <= 4'h0;
      modeSwitchAllowed <= 1'b0;
      seqRunning        <= 1'b0;
    end
    else
    begin
      // only source B carries the sequence
      sourceBActive <= segRampMode;
      if (!msActive || state_reg != mss_pkg::MSS_RUN)
      begin
        sourceBSpeed <= 16'h0000;
      end
      else
      begin
        sourceBSpeed <= dirSelect ? 16'(-spd_reg) : spd_reg;
      end
      rampTime      <= segRamp;
      accelTime     <= segRampMode ? segRamp : genAccel_reg;
      decelTime     <= segRampMode ? segRamp : genDecel_reg;
      activeSegment <= seg_reg;
      modeSwitchAllowed <= ctrlMode_reg >= mss_pkg::CTRL_SW_LO &&
                           ctrlMode_reg <= mss_pkg::CTRL_SW_HI;
      seqRunning    <= state_reg == mss_pkg::MSS_RUN;
    end
  end

  assign statusWord = {24'h0, seqRunning, 3'h0, seg_reg};

  // ****************************************************************
  // checks
  // ****************************************************************
  inactive_zero_a: assert property (@(posedge clk) disable iff (rst)
    !msActive |=> sourceBSpeed == 16'h0000) else $error("speed not zero when off");
  direct_seg_a: assert property (@(posedge clk) disable iff (rst)
    msActive && runMode_reg == mss_pkg::MODE_DIRECT |=> seg_reg == $past(selIn))
    else $error("direct select wrong");
  dir_invert_a: assert property (@(posedge clk) disable iff (rst)
    msActive && state_reg == mss_pkg::MSS_RUN && dirSelect
    |=> sourceBSpeed == 16'(-$past(spd_reg))) else $error("direction not inverted");
  mode_sw_a: assert property (@(posedge clk) disable iff (rst)
    ctrlMode_reg == 16'd6 |=> modeSwitchAllowed) else $error("mode switch flag");
  gen_ramp_a: assert property (@(posedge clk) disable iff (rst)
    !msActive |=> accelTime == $past(genAccel_reg)) else $error("general ramp");
  zero_ramp_a: assert property (@(posedge clk) disable iff (rst)
    rsel_reg == 16'h0000 |=> rampTime == 16'h0000) else $error("ramp not zero");
  single_stop_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == mss_pkg::MSS_DONE && msActive && runMode_reg == mss_pkg::MODE_SINGLE
    |=> state_reg == mss_pkg::MSS_DONE) else $error("single run restarted");
  cycle_wrap_a: assert property (@(posedge clk) disable iff (rst)
    state_reg == mss_pkg::MSS_RUN && msActive && runMode_reg == mss_pkg::MODE_CYCLE
    |=> state_reg != mss_pkg::MSS_DONE) else $error("cycle run stopped");
  cover_direct_c: cover property (@(posedge clk) msActive && runMode_reg == mss_pkg::MODE_DIRECT);
  cover_done_c: cover property (@(posedge clk) state_reg == mss_pkg::MSS_DONE);
  cover_wrap_c: cover property (@(posedge clk) seg_reg == 4'hf ##1 seg_reg == 4'h0);
endmodule

// File: rtl/mss_pkg.sv
// package: register map, field encodings and timing constants of the speed sequencer
package mss_pkg;
  // register byte offsets
  localparam logic [7:0] REG_RUN_MODE     = 8'h00;
  localparam logic [7:0] REG_END_SEG      = 8'h04;
  localparam logic [7:0] REG_TIME_UNIT    = 8'h08;
  localparam logic [7:0] REG_SRC_B_SEL    = 8'h0c;
  localparam logic [7:0] REG_COMBINE      = 8'h10;
  localparam logic [7:0] REG_GEN_ACCEL    = 8'h14;
  localparam logic [7:0] REG_GEN_DECEL    = 8'h18;
  localparam logic [7:0] REG_CTRL_MODE    = 8'h1c;
  localparam logic [7:0] REG_STATUS       = 8'h20;
  localparam logic [7:0] REG_RAMP_BASE    = 8'h40;
  localparam logic [7:0] REG_SEG_BASE     = 8'h80;
  localparam int         SEG_STRIDE       = 3;
  // reset values
  localparam logic [15:0] RST_RUN_MODE    = 16'h0001;
  localparam logic [15:0] RST_END_SEG     = 16'h0010;
  localparam logic [15:0] RST_TIME_UNIT   = 16'h0000;
  // encodings
  localparam logic [15:0] SRC_B_MULTISEG  = 16'h0005;
  localparam logic [15:0] COMB_B_ONLY     = 16'h0001;
  localparam logic [15:0] COMB_A_PLUS_B   = 16'h0002;
  localparam logic [15:0] COMB_A_B_SWITCH = 16'h0003;
  localparam logic [15:0] MODE_SINGLE     = 16'h0000;
  localparam logic [15:0] MODE_CYCLE      = 16'h0001;
  localparam logic [15:0] MODE_DIRECT     = 16'h0002;
  localparam logic [15:0] CTRL_SW_LO      = 16'h0003;
  localparam logic [15:0] CTRL_SW_HI      = 16'h0006;
  localparam int          NUM_SEG         = 16;
  localparam int          NUM_RAMP        = 4;
  // timing: one tenth of a second or of a minute
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          TENTH_SEC_MS    = 100;
  localparam int          TENTH_MIN_MS    = 6000;
  localparam int          TICK_SEC_CYC    = CLK_HZ / 1000 * TENTH_SEC_MS;
  localparam int          TICK_MIN_CYC    = CLK_HZ / 1000 * TENTH_MIN_MS;
  // ahb
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [1:0]  HTRANS_SEQ      = 2'h3;
  typedef enum logic [2:0] {
    MSS_IDLE = 3'b001,
    MSS_RUN  = 3'b010,
    MSS_DONE = 3'b100
  } mss_state_t;
endpackage

// File: rtl/mss_seg_mem.sv
// segment parameter memory: speed, run time and ramp select per segment
`timescale 1ns/1ps
module mss_seg_mem #(
  parameter int DEPTH = 48,
  parameter int AW    = 6
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [15:0]   wdata,
  input  wire logic [AW-1:0] raddrA,
  output logic      [15:0]   rdataA,
  input  wire logic [AW-1:0] raddrB,
  output logic      [15:0]   rdataB
);
  // every word powers up at zero, so segment 1 starts at zero speed
  logic [15:0] mem [DEPTH] = '{default: 16'h0000};

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdataA <= mem[raddrA];
    rdataB <= mem[raddrB];
  end
endmodule

// File: sim/mss_host_model.sv
// host controller model: drives the segment select inputs and direction select
`timescale 1ns/1ps
module mss_host_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] cmdSeg,
  input  wire logic       cmdDir,
  output logic            selBit0,
  output logic            selBit1,
  output logic            selBit2,
  output logic            selBit3,
  output logic            dirSel
);
  // ****************************************
  // select outputs, bit0 carries the lsb
  // ****************************************
  always_ff @(posedge clk or posedge rst)
    if (rst)
      {dirSel, selBit3, selBit2, selBit1, selBit0} <= 5'h00;
    else
      {dirSel, selBit3, selBit2, selBit1, selBit0} <= {cmdDir, cmdSeg};
endmodule

// File: sim/multi_segment_speed_sequencer_bench.sv
// testbench of the speed sequencer with host model and scoreboard
`timescale 1ns/1ps
module multi_segment_speed_sequencer_bench;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hrdata;
  logic [31:0] rdData;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  cmdSeg = 4'h0;
  logic        cmdDir = 1'b0;
  logic        s0, s1, s2, s3, dirSel;
  logic [15:0] sourceBSpeed, rampTime, accelTime, decelTime;
  logic [3:0]  activeSegment;
  logic        sourceBActive, modeSwitchAllowed, seqRunning;
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          seed = 32'hd171;
  int          qCode[$];
  logic [31:0] qVal[$];
  event        sampleEv;
  logic [15:0] spd[16];
  logic [15:0] rmp[5];
  string       nm[9] = '{"hrdata", "sourceBSpeed", "activeSegment", "sourceBActive",
                         "rampTime", "accelTime", "decelTime", "modeSwitchAllowed",
                         "seqRunning"};

  always #50 clk = ~clk;

  mss_host_model host (.clk(clk), .rst(rst), .cmdSeg(cmdSeg), .cmdDir(cmdDir),
    .selBit0(s0), .selBit1(s1), .selBit2(s2), .selBit3(s3), .dirSel(dirSel));

  mss_sequencer #(.TICK_SEC(10), .TICK_MIN(20)) dut (.clk(clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .segment_select_bit0(s0), .segment_select_bit1(s1), .segment_select_bit2(s2),
    .segment_select_bit3(s3), .dirSelect(dirSel), .sourceBSpeed(sourceBSpeed),
    .sourceBActive(sourceBActive), .rampTime(rampTime), .accelTime(accelTime),
    .decelTime(decelTime), .activeSegment(activeSegment),
    .modeSwitchAllowed(modeSwitchAllowed), .seqRunning(seqRunning));

  // ****************************************
  // bus master and note helpers
  // ****************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hreadyout !== 1'b1 && k < 40);
    if (k >= 40)
    begin
      $display("mismatch hreadyout expected 1 seen timeout");
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= mss_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    wait_rdy();
    rdData = hrdata;
  endtask

  task automatic note(input int c, input logic [31:0] v);
    qCode.push_back(c);
    qVal.push_back(v);
    -> sampleEv;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    ahb(a, 1'b1, d);
    // one more edge lets the registered outputs take up the new value
    @(posedge clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] v);
    ahb(a, 1'b0, 32'h0);
    note(0, v);
  endtask

  task automatic chk(input int c, input logic [31:0] v);
    @(negedge clk);
    note(c, v);
    // hand back on a rising edge so the next bus call starts there
    @(posedge clk);
  endtask

  task automatic seg_at(input int cyc, input int seg);
    repeat (cyc) @(posedge clk);
    chk(2, seg);
  endtask

  // ****************************************
  // watcher: compares each result with the oldest note
  // ****************************************
  always @(sampleEv)
  begin
    int          c;
    logic [31:0] v, seen;
    c = qCode.pop_front();
    v = qVal.pop_front();
    case (c)
      0: seen = rdData;
      1: seen = {16'h0, sourceBSpeed};
      2: seen = {28'h0, activeSegment};
      3: seen = {31'h0, sourceBActive};
      4: seen = {16'h0, rampTime};
      5: seen = {16'h0, accelTime};
      6: seen = {16'h0, decelTime};
      7: seen = {31'h0, modeSwitchAllowed};
      default: seen = {31'h0, seqRunning};
    endcase
    n_checks++;
    if (seen !== v)
    begin
      $display("mismatch %s expected %h seen %h", nm[c], v, seen);
      n_mismatch++;
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [15:0] e;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(32'h00, 32'h1);
    rd(32'h04, 32'h10);
    rd(32'h08, 32'h0);
    rd(32'h80, 32'h0);
    wr(32'h3c, 32'h1234);
    rd(32'h3c, 32'h0);
    rmp[0] = 16'h0;
    for (int i = 1; i < 5; i++)
    begin
      rmp[i] = $random(seed);
      wr(32'h40 + 4 * (i - 1), {16'h0, rmp[i]});
    end
    wr(32'h14, 32'h0123);
    wr(32'h18, 32'h0456);
    for (int i = 0; i < 16; i++)
    begin
      spd[i] = $random(seed);
      wr(32'h80 + 12 * i, {16'h0, spd[i]});
      wr(32'h84 + 12 * i, 32'h2);
      wr(32'h88 + 12 * i, i % 5);
      rd(32'h80 + 12 * i, {16'h0, spd[i]});
      rd(32'h88 + 12 * i, i % 5);
    end
    wr(32'h0c, 32'h5);
    for (int i = 0; i < 4; i++)
    begin
      wr(32'h10, i);
      chk(3, i != 0);
    end
    wr(32'h0c, 32'h4);
    chk(3, 32'h0);
    wr(32'h00, 32'h2);
    wr(32'h0c, 32'h5);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      cmdSeg <= i;
      cmdDir <= $random(seed);
      repeat (8) @(posedge clk);
      e = cmdDir ? -spd[i] : spd[i];
      chk(2, i);
      chk(1, {16'h0, e});
      chk(4, {16'h0, rmp[i % 5]});
      chk(5, {16'h0, rmp[i % 5]});
      chk(6, {16'h0, rmp[i % 5]});
    end
    wr(32'h0c, 32'h0);
    chk(3, 32'h0);
    chk(5, 32'h0123);
    chk(6, 32'h0456);
    for (int i = 0; i < 8; i++)
    begin
      wr(32'h1c, i);
      chk(7, i >= 3 && i <= 6);
    end
    wr(32'h00, 32'h0);
    wr(32'h04, 32'h3);
    wr(32'h0c, 32'h5);
    seg_at(10, 0);
    chk(8, 32'h1);
    seg_at(20, 1);
    seg_at(20, 2);
    repeat (40) @(posedge clk);
    chk(8, 32'h0);
    chk(1, 32'h0);
    wr(32'h0c, 32'h0);
    wr(32'h08, 32'h1);
    wr(32'h0c, 32'h5);
    seg_at(20, 0);
    seg_at(40, 1);
    wr(32'h0c, 32'h0);
    wr(32'h08, 32'h0);
    wr(32'h04, 32'h2);
    wr(32'h00, 32'h1);
    wr(32'h0c, 32'h5);
    seg_at(10, 0);
    seg_at(20, 1);
    seg_at(20, 0);
    chk(8, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(32'h00, 32'h1);
    rd(32'h04, 32'h10);
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule
